// *** design/irca_pkg.sv ***
// Constants for the interrupt router configuration function and its window
package irca_pkg;
    // Counts
    localparam int NUM_SEG = 2;
    localparam int NUM_INT = 10;
    localparam int MAX_INT = 24;

    // Configuration function holding the router header
    localparam logic [2:0] FUNC_ROUTER = 3'h1;

    // Header offsets
    localparam logic [7:0] HDR_IDENT = 8'h00;
    localparam logic [7:0] HDR_CMD = 8'h04;
    localparam logic [7:0] HDR_CLASS = 8'h08;
    localparam logic [7:0] HDR_BAR_LO = 8'h10;
    localparam logic [7:0] HDR_BAR_HI = 8'h14;
    localparam logic [7:0] HDR_SUBSYS = 8'h2C;

    // Command and state fields
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_MASTER_BIT = 2;
    localparam logic [31:0] CMD_RESET = 32'h0200_0000;
    localparam logic [1:0] CMD_EN_RESET = 2'h0;

    // Class and window base fields
    localparam logic [23:0] CLASS_CODE = 24'h08_0010;
    localparam int BAR_SHIFT = 12;
    localparam int BAR_BITS = 64 - BAR_SHIFT;
    localparam logic [11:0] BAR_LOW = 12'h004;
    localparam logic [51:0] BAR_RESET = 52'h0_0000_0000_0000;

    // Window offsets
    localparam logic [11:0] WIN_SELECT = 12'h000;
    localparam logic [11:0] WIN_DATA = 12'h010;

    // Internal router register indexes
    localparam logic [7:0] IDX_ID = 8'h00;
    localparam logic [7:0] IDX_VER = 8'h01;
    localparam logic [7:0] IDX_ARB = 8'h02;
    localparam logic [7:0] IDX_ENT0 = 8'h10;
    localparam logic [7:0] SEL_RESET = 8'h00;

    // Internal register fields
    localparam int ID_LSB = 24;
    localparam int MAXENT_LSB = 16;
    localparam logic [7:0] ROUTER_VERSION = 8'h11;
    localparam logic [3:0] ID_RESET = 4'h0;

    // Routing entry layout
    localparam int ENT_MASK_BIT = 16;
    localparam logic [63:0] ENT_RESET = 64'h0000_0000_0001_0000;
    localparam logic [63:0] ENT_WMASK = 64'hFFFF_FFFF_0001_FFFF;

    // Answer for a hidden function
    localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// *** design/irca_router_cfg.sv ***
// Interrupt router configuration function, indirect window and routing entries
//
// Functional notes
// [RULE_01] Router configuration function visible only in extended-function mode.
// [RULE_02] Outside that mode function 1 answers as absent, all ones.
// [RULE_03] In extended mode routing is programmed only through the indexed set.
// [RULE_04] One router header and register set per secondary segment.
// [RULE_05] Command bit 2 gates interrupt requests toward the host.
// [RULE_06] Command bit 1 gates decode of the memory window.
// [RULE_07] Base bits 63:12 are stored and mark the window start.
// [RULE_08] Base bits 11:0 read 004h and ignore writes.
// [RULE_09] Each router set serves ten interrupt inputs, one entry each.
// [RULE_10] Router registers reached only via select and data words in window.
// [RULE_11] Select bits 7:0 writable, 31:8 read zero, reset zero.
// [RULE_12] Data word writes go to the register chosen by the select.
// [RULE_13] Data word reads return the register chosen by the select.
// [RULE_14] Unimplemented indexes read zero and ignore writes.
// [RULE_15] Index 00h holds a writable four-bit identifier in bits 27:24.
// [RULE_16] Index 01h bits 23:16 read highest entry number, inputs minus one.
// [RULE_17] Entry mask bit 16 resets to one and suppresses its interrupt.
//
// Timing summary
// One-cycle answers on both access ports
// Config port answers function 1 in every mode
// Memory port answers only the accesses it claims
// Interrupt outputs lag their inputs by one cycle
// Reset is synchronous and clears all writable state except the entry mask bits, which it sets
// No byte enables: every access is a whole word
`timescale 1ns/1ns

module irca_router_cfg
    import irca_pkg::*;
#(
    parameter int NSEG = NUM_SEG,
    parameter int NINT = NUM_INT,
    parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'hA5A5, // Arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h3C, // Arbitrary value
    parameter logic [31:0] SUBSYS_CODE = 32'h0000_0000, // Arbitrary value
    localparam int SEGW = (NSEG > 1) ? $clog2(NSEG) : 1
) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Synchronous reset
    input wire logic ext_mode, // Extended-function mode selected
    input wire logic cfg_req, // Configuration access strobe
    input wire logic cfg_wr, // Configuration write
    input wire logic [2:0] cfg_func, // Function number
    input wire logic [SEGW-1:0] cfg_seg, // Secondary segment
    input wire logic [7:0] cfg_off, // Header byte offset
    input wire logic [31:0] cfg_wdata, // Configuration write data
    output logic [31:0] cfg_rdata, // Configuration read data
    output logic cfg_ack, // Configuration answer
    output logic cfg_present, // Function 1 exists
    input wire logic mem_req, // Memory access strobe
    input wire logic mem_wr, // Memory write
    input wire logic [63:0] mem_addr, // Memory byte address
    input wire logic [31:0] mem_wdata, // Memory write data
    output logic [31:0] mem_rdata, // Memory read data
    output logic mem_ack, // Memory answer, claimed access
    input wire logic [NSEG*NINT-1:0] irq_in, // Interrupt inputs
    output logic [NSEG*NINT-1:0] irq_out // Routed interrupt requests
);

    // Entry indexes must fit below the reserved top of the index space
    if (NSEG < 1 || NINT < 1 || NINT > MAX_INT) begin : g_chk
        $error("irca_router_cfg: unsupported NSEG or NINT");
    end

    // Derived index bounds
    // Entry e sits at two indexes, low half first
    // IDX_END is the first index past the table
    localparam logic [7:0] MAX_ENT = 8'(NINT - 1);
    localparam logic [7:0] IDX_END = 8'(IDX_ENT0 + 8'(2 * NINT));

    // Per-segment state
    // Only the two command enables are stored; the
    // remaining command and state bits are constant
    logic [CMD_MASTER_BIT:CMD_MEM_BIT] cmd_r [NSEG];
    logic [BAR_BITS-1:0] bar_r [NSEG];
    logic [7:0] sel_r [NSEG];
    logic [3:0] rid_r [NSEG];
    logic [3:0] arb_r [NSEG];
    logic [63:0] ent_r [NSEG*NINT];
    logic [31:0] cfg_rdata_r;
    logic cfg_ack_r;
    logic [31:0] mem_rdata_r;
    logic mem_ack_r;
    logic [NSEG*NINT-1:0] irq_out_r;

    // Decode and read-path nets
    logic cfg_take;
    logic cfg_vis;
    logic cfg_w;
    logic [7:0] cfg_word;
    logic [31:0] hdr_rd;
    logic [NSEG-1:0] mem_hit;
    logic mem_any;
    logic [SEGW-1:0] mem_seg;
    logic [11:0] win_off;
    logic wr_sel;
    logic wr_dat;
    logic [7:0] rsel;
    logic ent_ok;
    logic [7:0] ent_rel;
    logic [31:0] rtr_rd;
    logic [31:0] win_rd;

    // Configuration decode; function 0 belongs to the bridge proper
    // Function 1 is claimed in every mode so a hidden
    // function still answers, with all ones on reads
    // Offset bits 1:0 ignored, whole words only
    assign cfg_take = cfg_req && (cfg_func == FUNC_ROUTER);
    assign cfg_vis = cfg_take && ext_mode; // [RULE_01]
    assign cfg_w = cfg_vis && cfg_wr; // [RULE_02]
    assign cfg_word = {cfg_off[7:2], 2'b00};

    // Header read mux for the addressed segment
    // Reserved words read zero; status half is constant
    // Segment number picks which copy of the state is shown
    always_comb begin
        hdr_rd = ZERO32;
        case (cfg_word)
            HDR_IDENT: hdr_rd = {DEVICE_CODE, VENDOR_CODE};
            HDR_CMD: begin
                hdr_rd = CMD_RESET;
                hdr_rd[CMD_MASTER_BIT:CMD_MEM_BIT] = cmd_r[cfg_seg];
            end
            HDR_CLASS: hdr_rd = {CLASS_CODE, REVISION_CODE};
            HDR_BAR_LO: hdr_rd = {bar_r[cfg_seg][19:0], BAR_LOW}; // [RULE_08]
            HDR_BAR_HI: hdr_rd = bar_r[cfg_seg][BAR_BITS-1:20];
            HDR_SUBSYS: hdr_rd = SUBSYS_CODE;
            default: hdr_rd = ZERO32;
        endcase
    end

    // Window decode; lowest segment wins if two bases overlap
    // Overlap is a software error; this only makes it deterministic
    // Scan runs downward so the lowest hit is written last
    always_comb begin
        mem_any = 1'b0;
        mem_seg = '0;
        for (int s = NSEG - 1; s >= 0; s--) begin
            if (mem_hit[s]) begin
                mem_any = 1'b1;
                mem_seg = SEGW'(s);
            end
        end
    end

    // Claim per segment: mode, memory enable and page match
    // Base is compared whole, so the window is exactly 4 KB
    for (genvar s = 0; s < NSEG; s++) begin : g_hit
        assign mem_hit[s] = mem_req && ext_mode && cmd_r[s][CMD_MEM_BIT] // [RULE_06]
            && (mem_addr[63:BAR_SHIFT] == bar_r[s]); // [RULE_07]
    end

    // Window offsets and the select of the claiming segment
    // Unaligned offsets fall to the read-zero default
    assign win_off = mem_addr[11:0];
    assign wr_sel = mem_any && mem_wr && (win_off == WIN_SELECT); // [RULE_10]
    assign wr_dat = mem_any && mem_wr && (win_off == WIN_DATA); // [RULE_10]
    assign rsel = sel_r[mem_seg];
    assign ent_ok = (rsel >= IDX_ENT0) && (rsel < IDX_END); // [RULE_09]
    assign ent_rel = rsel - IDX_ENT0;

    // Indirect read of the selected router register
    // Odd table index is the upper entry half
    // Table range checked first, so the case stays small
    // Anything else reads zero, reserved indexes included
    always_comb begin
        rtr_rd = ZERO32;
        if (ent_ok) begin
            if (ent_rel[0]) begin
                rtr_rd = ent_r[int'(mem_seg) * NINT + int'(ent_rel[7:1])][63:32]; // [RULE_13]
            end else begin
                rtr_rd = ent_r[int'(mem_seg) * NINT + int'(ent_rel[7:1])][31:0]; // [RULE_13]
            end
        end else begin
            case (rsel)
                IDX_ID: rtr_rd[ID_LSB+:4] = rid_r[mem_seg]; // [RULE_15]
                IDX_VER: begin
                    rtr_rd[MAXENT_LSB+:8] = MAX_ENT; // [RULE_16]
                    rtr_rd[7:0] = ROUTER_VERSION;
                end
                IDX_ARB: rtr_rd[ID_LSB+:4] = arb_r[mem_seg];
                default: rtr_rd = ZERO32; // [RULE_14]
            endcase
        end
    end

    // Window word mux; other window offsets read zero
    // Select reads back so software can save and restore it
    // Only the two decoded words carry data
    always_comb begin
        win_rd = ZERO32;
        case (win_off)
            WIN_SELECT: win_rd = {24'h00_0000, rsel}; // [RULE_11]
            WIN_DATA: win_rd = rtr_rd;
            default: win_rd = ZERO32;
        endcase
    end

    // Per-segment header and router state
    // Each segment has a private header, select and table
    // Writes reach one segment only, chosen by decode
    for (genvar s = 0; s < NSEG; s++) begin : g_seg // [RULE_04]
        logic cfg_me;
        logic mem_me;
        assign cfg_me = cfg_w && (cfg_seg == SEGW'(s));
        assign mem_me = mem_any && (mem_seg == SEGW'(s));

        // Command enables
        // Hidden writes are dropped through cfg_w
        // Other bits of the written word are ignored
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                cmd_r[s] <= CMD_EN_RESET;
            end else if (cfg_me && cfg_word == HDR_CMD) begin
                cmd_r[s] <= cfg_wdata[CMD_MASTER_BIT:CMD_MEM_BIT];
            end
        end

        // Window base, low twelve bits are hardwired
        // Halves written independently, in either order
        // A half-written base may decode a stray page
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                bar_r[s] <= BAR_RESET;
            end else if (cfg_me && cfg_word == HDR_BAR_LO) begin
                bar_r[s][19:0] <= cfg_wdata[31:BAR_SHIFT]; // [RULE_07]
            end else if (cfg_me && cfg_word == HDR_BAR_HI) begin
                bar_r[s][BAR_BITS-1:20] <= cfg_wdata; // [RULE_07]
            end
        end

        // Select word
        // Takes effect for the access in the next cycle
        // Upper bits of the written word are dropped
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                sel_r[s] <= SEL_RESET; // [RULE_11]
            end else if (mem_me && wr_sel) begin
                sel_r[s] <= mem_wdata[7:0]; // [RULE_11]
            end
        end

        // Identifier and arbitration words
        // Only bits 27:24 are stored; the rest read zero
        // Table indexes are excluded so they never alias here
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                rid_r[s] <= ID_RESET;
                arb_r[s] <= ID_RESET;
            end else if (mem_me && wr_dat && !ent_ok) begin
                if (rsel == IDX_ID) begin
                    rid_r[s] <= mem_wdata[ID_LSB+:4]; // [RULE_15]
                end
                if (rsel == IDX_ARB) begin
                    arb_r[s] <= mem_wdata[ID_LSB+:4];
                end
            end
        end

        // Routing entries, written one half at a time
        // Low half keeps read-only bits at zero via the mask
        // Upper half is fully writable
        // Mask set at reset so nothing fires before setup
        for (genvar e = 0; e < NINT; e++) begin : g_ent // [RULE_09]
            logic hit_e;
            assign hit_e = mem_me && wr_dat && ent_ok && (ent_rel[7:1] == 7'(e)); // [RULE_12]
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    ent_r[s*NINT+e] <= ENT_RESET; // [RULE_17]
                end else if (hit_e && ent_rel[0]) begin
                    ent_r[s*NINT+e][63:32] <= mem_wdata & ENT_WMASK[63:32]; // [RULE_12]
                end else if (hit_e) begin
                    ent_r[s*NINT+e][31:0] <= (mem_wdata & ENT_WMASK[31:0]) // [RULE_12]
                        | (ent_r[s*NINT+e][31:0] & ~ENT_WMASK[31:0]);
                end
            end

            // Request reaches the host only if unmasked and mastering allowed
            // Registered, so requests lag the inputs by one cycle
            // Mode off forces low; routing is then done elsewhere
            // Level only: no edge capture, no pending state
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    irq_out_r[s*NINT+e] <= 1'b0;
                end else begin
                    irq_out_r[s*NINT+e] <= irq_in[s*NINT+e] && ext_mode // [RULE_03]
                        && cmd_r[s][CMD_MASTER_BIT] // [RULE_05]
                        && !ent_r[s*NINT+e][ENT_MASK_BIT]; // [RULE_17]
                end
            end
        end
    end

    // Configuration answer, one cycle after the strobe
    // Read data holds until the next function 1 read
    // Hidden function reads all ones, as for an absent one
    // Writes are acknowledged whether or not they land
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cfg_ack_r <= 1'b0;
            cfg_rdata_r <= ZERO32;
        end else begin
            cfg_ack_r <= cfg_take;
            if (cfg_take && !cfg_wr) begin
                cfg_rdata_r <= cfg_vis ? hdr_rd : ALL_ONES; // [RULE_02]
            end
        end
    end

    // Memory answer only for claimed accesses; others are left to abort
    // Read data holds until the next claimed read
    // Unused window offsets are still acknowledged
    // No wait states: every claimed access answers next cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mem_ack_r <= 1'b0;
            mem_rdata_r <= ZERO32;
        end else begin
            mem_ack_r <= mem_any; // [RULE_06]
            if (mem_any && !mem_wr) begin
                mem_rdata_r <= win_rd; // [RULE_13]
            end
        end
    end

    // Outputs other than cfg_present come straight from flops
    // Present follows the mode pin without delay
    assign cfg_ack = cfg_ack_r;
    assign cfg_rdata = cfg_rdata_r;
    assign cfg_present = ext_mode; // [RULE_01]
    assign mem_ack = mem_ack_r;
    assign mem_rdata = mem_rdata_r;
    assign irq_out = irq_out_r;

endmodule // irca_router_cfg

// *** dv/irca_router_cfg_chk.sv ***
// Concurrent checks on the router configuration ports
`timescale 1ns/1ns
module irca_router_cfg_chk
    import irca_pkg::*;
#(
    parameter int NSEG = NUM_SEG,
    parameter int NINT = NUM_INT
) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic ext_mode, // Mode
    input wire logic cfg_req, // Strobe
    input wire logic [2:0] cfg_func, // Function
    input wire logic cfg_wr, // Write
    input wire logic [31:0] cfg_rdata, // Read data
    input wire logic cfg_ack, // Answer
    input wire logic cfg_present, // Exists
    input wire logic mem_req, // Strobe
    input wire logic [31:0] mem_rdata, // Read data
    input wire logic mem_ack, // Answer
    input wire logic [NSEG*NINT-1:0] irq_in, // Inputs
    input wire logic [NSEG*NINT-1:0] irq_out // Requests
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Config answers follow function 1 only
    property p_cfg_ack; cfg_req && cfg_func == FUNC_ROUTER |=> cfg_ack; endproperty
    a_cfg_ack: assert property (p_cfg_ack) else $error("cfg ack missing");
    property p_cfg_none; !(cfg_req && cfg_func == FUNC_ROUTER) |=> !cfg_ack; endproperty
    a_cfg_none: assert property (p_cfg_none) else $error("cfg ack unasked");
    property p_present; cfg_present == ext_mode; endproperty
    a_present: assert property (p_present) else $error("present wrong");
    // Hidden function reads all ones
    property p_hidden; cfg_req && cfg_func == FUNC_ROUTER && !cfg_wr && !ext_mode
        |=> cfg_rdata == ALL_ONES; endproperty
    a_hidden: assert property (p_hidden) else $error("hidden read wrong");
    // Memory answers need a strobe and the mode
    property p_mem_req; !mem_req |=> !mem_ack; endproperty
    a_mem_req: assert property (p_mem_req) else $error("mem ack unasked");
    property p_mem_mode; mem_req && !ext_mode |=> !mem_ack; endproperty
    a_mem_mode: assert property (p_mem_mode) else $error("mem ack hidden");
    property p_mrd_hold; !mem_ack |-> $stable(mem_rdata); endproperty
    a_mrd_hold: assert property (p_mrd_hold) else $error("mem rdata moved");
    // Requests only from active inputs and only in the mode
    property p_irq_src; 1'b1 |=> (irq_out & ~$past(irq_in)) == '0; endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without input");
    property p_irq_mode; !ext_mode |=> irq_out == '0; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq in other mode");
endmodule // irca_router_cfg_chk

bind irca_router_cfg irca_router_cfg_chk #(.NSEG(NSEG), .NINT(NINT)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .ext_mode(ext_mode), .cfg_req(cfg_req),
    .cfg_func(cfg_func), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .cfg_present(cfg_present), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .irq_in(irq_in), .irq_out(irq_out));

// *** dv/irca_host_model.sv ***
// Host model issuing configuration and memory accesses
`timescale 1ns/1ns
module irca_host_model (
    input wire logic sys_clk, // Clock
    output logic cfg_req, // Config strobe
    output logic cfg_wr, // Config write
    output logic [2:0] cfg_func, // Function
    output logic [0:0] cfg_seg, // Segment
    output logic [7:0] cfg_off, // Offset
    output logic [31:0] cfg_wdata, // Config data
    input wire logic [31:0] cfg_rdata, // Config read data
    input wire logic cfg_ack, // Config answer
    output logic mem_req, // Memory strobe
    output logic mem_wr, // Memory write
    output logic [63:0] mem_addr, // Address
    output logic [31:0] mem_wdata, // Memory data
    input wire logic [31:0] mem_rdata, // Memory read data
    input wire logic mem_ack // Memory answer
);
    // Idle bus at time zero
    initial begin
        {cfg_req, cfg_wr, cfg_func, cfg_seg, cfg_off, cfg_wdata} = '0;
        {mem_req, mem_wr, mem_addr, mem_wdata} = '0;
    end
    // One-edge strobe; answer read in the following cycle
    task automatic acc(input bit mem, input bit wr, input logic [2:0] fn, input logic seg,
        input logic [63:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(negedge sys_clk);
        cfg_req = !mem;
        mem_req = mem;
        cfg_wr = wr;
        mem_wr = wr;
        cfg_func = fn;
        cfg_seg = seg;
        cfg_off = a[7:0];
        mem_addr = a;
        cfg_wdata = wd;
        mem_wdata = wd;
        @(negedge sys_clk);
        cfg_req = 0;
        mem_req = 0;
        // Released data lines flip so stale values never look valid
        cfg_wdata = ~wd;
        mem_wdata = ~wd;
        rd = mem ? mem_rdata : cfg_rdata;
        ack = mem ? mem_ack : cfg_ack;
    endtask
endmodule // irca_host_model

// *** dv/irca_router_cfg_tb.sv ***
// Self-checking bench for the router configuration function
`timescale 1ns/1ns
module irca_router_cfg_tb;
    import irca_pkg::*;
    localparam logic [63:0] BASE = 64'h0000_0001_0001_2000;
    localparam logic [63:0] DATA = {BASE[63:12], WIN_DATA};
    logic sys_clk = 0;
    logic resetn = 0;
    logic ext_mode = 0;
    logic [19:0] irq_in = '0;
    logic [19:0] irq_out;
    logic cfg_req, cfg_wr, cfg_ack, cfg_present, mem_req, mem_wr, mem_ack, ack;
    logic [31:0] cfg_wdata, cfg_rdata, mem_wdata, mem_rdata, rd;
    logic [2:0] cfg_func;
    logic [0:0] cfg_seg;
    logic [7:0] cfg_off;
    logic [63:0] mem_addr;
    int fail_count = 0;
    int check_count = 0;

    always #5 sys_clk = ~sys_clk;

    irca_router_cfg u_dut (.sys_clk(sys_clk), .resetn(resetn), .ext_mode(ext_mode),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_func(cfg_func), .cfg_seg(cfg_seg),
        .cfg_off(cfg_off), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .cfg_present(cfg_present), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_in(irq_in),
        .irq_out(irq_out));
    irca_host_model u_host (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_func(cfg_func), .cfg_seg(cfg_seg), .cfg_off(cfg_off), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .mem_req(mem_req), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Config and window accesses with their expectations
    task automatic cw(input logic s, input logic [7:0] o, input logic [31:0] d);
        u_host.acc(0, 1, FUNC_ROUTER, s, {56'h0, o}, d, rd, ack);
    endtask
    task automatic cr(input logic s, input logic [7:0] o, input logic [31:0] e);
        u_host.acc(0, 0, FUNC_ROUTER, s, {56'h0, o}, 32'h0, rd, ack);
        chk("cfg_ack", {31'h0, ack}, 32'h1);
        chk("cfg_rdata", rd, e);
    endtask
    task automatic mw(input logic [63:0] a, input logic [31:0] d, input logic ea);
        u_host.acc(1, 1, 3'h0, 1'b0, a, d, rd, ack);
        chk("mem_ack", {31'h0, ack}, {31'h0, ea});
    endtask
    task automatic mr(input logic [63:0] a, input logic [31:0] e);
        u_host.acc(1, 0, 3'h0, 1'b0, a, 32'h0, rd, ack);
        chk("mem_ack", {31'h0, ack}, 32'h1);
        chk("mem_rdata", rd, e);
    endtask
    // Select word first, then the data word
    task automatic ir(input logic [7:0] i, input logic [31:0] e);
        mw(BASE, {24'h0, i}, 1);
        mr(DATA, e);
    endtask
    task automatic iw(input logic [7:0] i, input logic [31:0] d);
        mw(BASE, {24'h0, i}, 1);
        mw(DATA, d, 1);
    endtask

    // Hang guard well above the run length
    initial begin
        #500_000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (2) @(negedge sys_clk);
        resetn = 1;
        cr(0, HDR_IDENT, ALL_ONES);
        cw(0, HDR_CMD, 32'h0000_0006);
        mw(BASE, 32'h0, 0);
        u_host.acc(0, 0, 3'h0, 1'b0, 64'h0, 32'h0, rd, ack);
        chk("cfg_ack_f0", {31'h0, ack}, 32'h0);
        ext_mode = 1;
        #1;
        chk("cfg_present", {31'h0, cfg_present}, 32'h1);
        cr(0, HDR_IDENT, 32'hA5A5_5A5A);
        cr(0, HDR_CMD, CMD_RESET);
        cr(0, HDR_CLASS, {CLASS_CODE, 8'h3C});
        cr(0, HDR_BAR_LO, 32'h0000_0004);
        cw(0, HDR_BAR_LO, 32'h0001_2FFF);
        cr(0, HDR_BAR_LO, 32'h0001_2004);
        cw(0, HDR_BAR_HI, 32'h0000_0001);
        cr(0, HDR_BAR_HI, 32'h0000_0001);
        cr(1, HDR_BAR_LO, 32'h0000_0004);
        mw(BASE, 32'h0, 0);
        cw(0, HDR_CMD, ALL_ONES);
        cr(0, HDR_CMD, 32'h0200_0006);
        mr(BASE, 32'h0);
        mw(BASE, 32'hFFFF_FF01, 1);
        mr(BASE, 32'h0000_0001);
        mr(DATA, 32'h0009_0011);
        iw(IDX_ID, ALL_ONES);
        ir(IDX_ID, 32'h0F00_0000);
        iw(8'h05, ALL_ONES);
        ir(8'h05, 32'h0);
        ir(8'h24, 32'h0);
        for (int e = 0; e < 10; e++) begin
            ir(IDX_ENT0 + 8'(2 * e), ENT_RESET[31:0]);
        end
        iw(IDX_ENT0 + 8'h1, ALL_ONES);
        ir(IDX_ENT0 + 8'h1, ALL_ONES);
        iw(IDX_ENT0 + 8'h2, ALL_ONES);
        ir(IDX_ENT0 + 8'h2, 32'h0001_FFFF);
        mr({BASE[63:12], 12'h020}, 32'h0);
        mw({BASE[63:12] + 52'h1, 12'h000}, 32'h0, 0);
        // Masked entries hold every input back
        irq_in = 20'hF_FFFF;
        repeat (2) @(negedge sys_clk);
        chk("irq_masked", {12'h0, irq_out}, 32'h0);
        iw(IDX_ENT0, 32'h0);
        iw(IDX_ENT0 + 8'h12, 32'h0);
        repeat (2) @(negedge sys_clk);
        chk("irq_open", {12'h0, irq_out}, 32'h0000_0201);
        cw(0, HDR_CMD, 32'h0000_0002);
        repeat (2) @(negedge sys_clk);
        chk("irq_master_off", {12'h0, irq_out}, 32'h0);
        ext_mode = 0;
        mw(BASE, 32'h0, 0);
        cr(0, HDR_CMD, ALL_ONES);
        stop_test();
    end
endmodule // irca_router_cfg_tb
